// ===== hdl/phy_mgmt_regs.sv
// Management register block: serial management slave with partner page, tuning and link summary registers
// Functional notes
// - Partner page code low four bits are read-only, reset zero, loaded from received page.
// - Register numbers nine to fifteen are reserved and have no function.
// - Command override bit at tuning bit fifteen is writable, resets zero, self-clears.
// - Tuning bits ten to six show the address: top bit one, rest strapped.
// - Tuning bit five puts the scrambler in test mode; resets zero.
// - Tuning bit three selects NRZI when one, NRZ when zero; resets one.
// - Tuning bit two allows invalid code groups to be sent; resets zero.
// - Tuning bit zero bypasses the scrambler; resets zero.
// - Summary bit fourteen reports duplex: zero half, one full.
// - Summary bits thirteen and twelve show latched progress bits two and one.
// - Summary bit eleven shows latched progress bit zero, completing the code.
`timescale 1ns/10ps
module phy_mgmt_regs (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       mdc,
  input  wire logic                       mdioIn,
  output logic                            mdioOut,
  output logic                            mdioOe,
  input  wire logic [3:0]                 strapAddr,
  input  wire logic [15:0]                pageCode,
  input  wire logic                       pageStrobe,
  input  wire phy_regs_pkg::link_status_t linkStatus,
  output phy_regs_pkg::tuning_t           tuning,
  output logic                            cmdOverride
);
  logic [phy_regs_pkg::SYNC_WIDTH-1:0] syncOut;
  logic                                mdcS;
  logic                                mdioS;
  logic [3:0]                          strapS;
  logic                                mdcPrev_q;
  logic                                rise;

  phy_regs_pkg::mgmt_state_t state_q;
  phy_regs_pkg::mgmt_state_t state_d;
  logic [5:0]                onesCnt_q;
  logic [5:0]                onesCnt_d;
  logic [4:0]                bitCnt_q;
  logic [4:0]                bitCnt_d;
  logic [15:0]               shift_q;
  logic [15:0]               shift_d;
  logic [4:0]                regNum_q;
  logic [4:0]                regNum_d;
  logic                      isRead_q;
  logic                      isRead_d;
  logic                      mdioOut_d;
  logic                      mdioOe_d;
  logic                      tuneWrite;
  logic [15:0]               writeWord;
  logic [11:0]               header;

  logic [15:0]               pageCode_q;
  logic [15:0]               pageCode_d;
  phy_regs_pkg::tuning_t     tuning_q;
  phy_regs_pkg::tuning_t     tuning_d;
  logic                      cmdOverride_q;
  logic                      cmdOverride_d;
  logic [2:0]                progress_q;
  logic [2:0]                progress_d;
  logic [3:0]                strapAddr_q;
  logic [3:0]                strapAddr_d;
  logic [2:0]                strapCnt_q;
  logic [2:0]                strapCnt_d;
  logic                      strapDone_q;
  logic                      strapDone_d;
  logic [4:0]                phyAddr;

  input_sync input_sync_inst (
    .clk     (clk),
    .resetn  (resetn),
    .rawIn   ({strapAddr, mdioIn, mdc}),
    .syncOut (syncOut)
  );

  assign mdcS    = syncOut[0];
  assign mdioS   = syncOut[1];
  assign strapS  = syncOut[5:2];
  assign rise    = mdcS & ~mdcPrev_q;
  assign phyAddr = {phy_regs_pkg::PHYAD_TOP, strapAddr_q};

  function automatic logic isReserved(input logic [4:0] regNum);
    isReserved = (regNum >= phy_regs_pkg::REG_RSVD_FIRST) && (regNum <= phy_regs_pkg::REG_RSVD_LAST);
  endfunction

  function automatic logic [15:0] readWord(
    input logic [4:0]                 regNum,
    input logic [15:0]                page,
    input phy_regs_pkg::tuning_t      tune,
    input logic [4:0]                 addr,
    input phy_regs_pkg::link_status_t stat,
    input logic [2:0]                 prog
  );
    logic [15:0] word;
    word = phy_regs_pkg::WORD_ZERO;
    if (isReserved(regNum)) begin
      word = phy_regs_pkg::WORD_ZERO;
    end else if (regNum == phy_regs_pkg::REG_PARTNER_PAGE) begin
      word = page;
    end else if (regNum == phy_regs_pkg::REG_TUNING) begin
      word[phy_regs_pkg::ADDR_HI:phy_regs_pkg::ADDR_LO] = addr;
      word[phy_regs_pkg::CIPHER_TEST_BIT]               = tune.cipherTest;
      word[phy_regs_pkg::NRZI_BIT]                      = tune.nrzi;
      word[phy_regs_pkg::TX_INVALID_BIT]                = tune.txInvalid;
      word[phy_regs_pkg::CIPHER_OFF_BIT]                = tune.cipherOff;
    end else if (regNum == phy_regs_pkg::REG_LINK_SUMMARY) begin
      word[phy_regs_pkg::SPEED_BIT]                     = stat.speed100;
      word[phy_regs_pkg::DUPLEX_BIT]                    = stat.fullDuplex;
      word[phy_regs_pkg::PROG_HI:phy_regs_pkg::PROG_LO] = prog;
    end
    return word;
  endfunction

  // Serial frame engine: samples and drives on synchronised MDC rising edges
  always_comb begin
    state_d   = state_q;
    onesCnt_d = onesCnt_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    regNum_d  = regNum_q;
    isRead_d  = isRead_q;
    mdioOut_d = mdioOut;
    mdioOe_d  = mdioOe;
    tuneWrite = 1'b0;
    writeWord = {shift_q[14:0], mdioS};
    header    = writeWord[11:0];
    if (rise) begin
      unique case (state_q)
        phy_regs_pkg::S_PRE: begin
          if (mdioS) begin
            if (onesCnt_q != phy_regs_pkg::PREAMBLE_MIN) begin
              onesCnt_d = onesCnt_q + 6'h01;
            end
          end else if (onesCnt_q == phy_regs_pkg::PREAMBLE_MIN) begin
            state_d = phy_regs_pkg::S_START;
          end else begin
            onesCnt_d = '0;
          end
        end
        phy_regs_pkg::S_START: begin
          onesCnt_d = '0;
          bitCnt_d  = '0;
          state_d   = mdioS ? phy_regs_pkg::S_HEAD : phy_regs_pkg::S_PRE;
        end
        phy_regs_pkg::S_HEAD: begin
          shift_d  = writeWord;
          bitCnt_d = bitCnt_q + 5'h01;
          if (bitCnt_q == phy_regs_pkg::HEAD_LAST) begin
            bitCnt_d = '0;
            regNum_d = header[phy_regs_pkg::REGNUM_HI:0];
            isRead_d = (header[phy_regs_pkg::OP_HI:phy_regs_pkg::OP_LO] == phy_regs_pkg::OP_READ);
            if (header[phy_regs_pkg::PHY_HI:phy_regs_pkg::PHY_LO] == phyAddr &&
                (header[phy_regs_pkg::OP_HI:phy_regs_pkg::OP_LO] == phy_regs_pkg::OP_READ ||
                 header[phy_regs_pkg::OP_HI:phy_regs_pkg::OP_LO] == phy_regs_pkg::OP_WRITE)) begin
              state_d = phy_regs_pkg::S_TURN;
            end else begin
              state_d = phy_regs_pkg::S_PRE;
            end
          end
        end
        phy_regs_pkg::S_TURN: begin
          if (isRead_q) begin
            // Second turnaround bit is driven low, then the word follows
            mdioOe_d  = 1'b1;
            mdioOut_d = 1'b0;
            shift_d   = readWord(regNum_q, pageCode_q, tuning_q, phyAddr, linkStatus, progress_q);
            state_d   = phy_regs_pkg::S_READ;
          end else if (bitCnt_q == phy_regs_pkg::TURN_LAST) begin
            bitCnt_d = '0;
            state_d  = phy_regs_pkg::S_WRITE;
          end else begin
            bitCnt_d = bitCnt_q + 5'h01;
          end
        end
        phy_regs_pkg::S_READ: begin
          if (bitCnt_q == phy_regs_pkg::DATA_BITS) begin
            mdioOe_d  = 1'b0;
            mdioOut_d = 1'b0;
            bitCnt_d  = '0;
            state_d   = phy_regs_pkg::S_PRE;
          end else begin
            mdioOut_d = shift_q[15];
            shift_d   = {shift_q[14:0], 1'b0};
            bitCnt_d  = bitCnt_q + 5'h01;
          end
        end
        phy_regs_pkg::S_WRITE: begin
          shift_d  = writeWord;
          bitCnt_d = bitCnt_q + 5'h01;
          if (bitCnt_q == phy_regs_pkg::DATA_LAST) begin
            tuneWrite = (regNum_q == phy_regs_pkg::REG_TUNING);
            bitCnt_d  = '0;
            state_d   = phy_regs_pkg::S_PRE;
          end
        end
        default: begin
          mdioOe_d = 1'b0;
          state_d  = phy_regs_pkg::S_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= phy_regs_pkg::S_PRE;
      onesCnt_q <= '0;
      bitCnt_q  <= '0;
      shift_q   <= '0;
      regNum_q  <= '0;
      isRead_q  <= 1'b0;
      mdioOut   <= 1'b0;
      mdioOe    <= 1'b0;
      mdcPrev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      onesCnt_q <= onesCnt_d;
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      regNum_q  <= regNum_d;
      isRead_q  <= isRead_d;
      mdioOut   <= mdioOut_d;
      mdioOe    <= mdioOe_d;
      mdcPrev_q <= mdcS;
    end
  end

  // Register contents and strap capture
  always_comb begin
    pageCode_d    = pageCode_q;
    tuning_d      = tuning_q;
    cmdOverride_d = 1'b0;
    progress_d    = progress_q;
    strapAddr_d   = strapAddr_q;
    strapCnt_d    = strapCnt_q;
    strapDone_d   = strapDone_q;
    if (pageStrobe) begin
      pageCode_d                              = pageCode;
      pageCode_d[phy_regs_pkg::PAGE_RSVD_BIT] = 1'b0;
    end
    // Progress code is frozen while a word is being shifted out
    if (state_q != phy_regs_pkg::S_TURN && state_q != phy_regs_pkg::S_READ) begin
      progress_d = linkStatus.progress;
    end
    if (tuneWrite) begin
      cmdOverride_d      = writeWord[phy_regs_pkg::CMD_OVR_BIT];
      tuning_d.cipherTest = writeWord[phy_regs_pkg::CIPHER_TEST_BIT];
      tuning_d.nrzi       = writeWord[phy_regs_pkg::NRZI_BIT];
      tuning_d.txInvalid  = writeWord[phy_regs_pkg::TX_INVALID_BIT];
      tuning_d.cipherOff  = writeWord[phy_regs_pkg::CIPHER_OFF_BIT];
    end
    if (!strapDone_q) begin
      if (strapCnt_q == phy_regs_pkg::STRAP_SETTLE) begin
        strapAddr_d = strapS;
        strapDone_d = 1'b1;
      end else begin
        strapCnt_d = strapCnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pageCode_q    <= phy_regs_pkg::WORD_ZERO;
      tuning_q      <= phy_regs_pkg::TUNING_RESET;
      cmdOverride_q <= 1'b0;
      progress_q    <= '0;
      strapAddr_q   <= '0;
      strapCnt_q    <= '0;
      strapDone_q   <= 1'b0;
    end else begin
      pageCode_q    <= pageCode_d;
      tuning_q      <= tuning_d;
      cmdOverride_q <= cmdOverride_d;
      progress_q    <= progress_d;
      strapAddr_q   <= strapAddr_d;
      strapCnt_q    <= strapCnt_d;
      strapDone_q   <= strapDone_d;
    end
  end

  assign tuning      = tuning_q;
  assign cmdOverride = cmdOverride_q;

  page_capture_a: assert property (@(posedge clk) disable iff (!resetn)
    pageStrobe |=> pageCode_q[3:0] == $past(pageCode[3:0]))
    else $error("partner page code not captured");

  reserved_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (rise && state_q == phy_regs_pkg::S_TURN && isRead_q && isReserved(regNum_q)) |=> shift_q == 16'h0000)
    else $error("reserved register read not zero");

  override_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    (tuneWrite && writeWord[phy_regs_pkg::CMD_OVR_BIT]) |=> cmdOverride ##1 !cmdOverride)
    else $error("command override not a single pulse");

  strap_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(strapDone_q) |-> strapAddr_q == $past(strapS) && phyAddr[4] == 1'b1)
    else $error("address not latched from straps");

  test_mode_a: assert property (@(posedge clk) disable iff (!resetn)
    tuneWrite |=> tuning.cipherTest == $past(writeWord[phy_regs_pkg::CIPHER_TEST_BIT]))
    else $error("scrambler test mode not updated");

  nrzi_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !tuneWrite |=> $stable(tuning.nrzi))
    else $error("encoding select changed without a write");

  tx_invalid_a: assert property (@(posedge clk) disable iff (!resetn)
    (tuneWrite && !writeWord[phy_regs_pkg::TX_INVALID_BIT]) |=> !tuning.txInvalid)
    else $error("invalid code transmit not disabled");

  cipher_bypass_a: assert property (@(posedge clk) disable iff (!resetn)
    (tuneWrite && writeWord[phy_regs_pkg::CIPHER_OFF_BIT]) |=> tuning.cipherOff)
    else $error("scrambler bypass not set");

  rate_duplex_a: assert property (@(posedge clk) disable iff (!resetn)
    (rise && state_q == phy_regs_pkg::S_TURN && isRead_q && regNum_q == phy_regs_pkg::REG_LINK_SUMMARY)
      |=> shift_q[15:14] == {$past(linkStatus.speed100), $past(linkStatus.fullDuplex)})
    else $error("rate or duplex misreported");

  progress_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (rise && state_q == phy_regs_pkg::S_TURN && isRead_q && regNum_q == phy_regs_pkg::REG_LINK_SUMMARY)
      |=> shift_q[13:11] == $past(progress_q))
    else $error("progress code misreported");

  frame_length_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(mdioOe) |-> $past(bitCnt_q) == 5'h10)
    else $error("read word not 16 bits");
endmodule

// ===== hdl/phy_regs_pkg.sv
// Shared constants, types and states of the management register block
package phy_regs_pkg;
  // Register numbers on the management bus
  localparam logic [4:0] REG_PARTNER_PAGE = 5'h08;
  localparam logic [4:0] REG_RSVD_FIRST   = 5'h09;
  localparam logic [4:0] REG_RSVD_LAST    = 5'h0F;
  localparam logic [4:0] REG_TUNING       = 5'h10;
  localparam logic [4:0] REG_LINK_SUMMARY = 5'h11;

  // Frame layout
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [5:0] PREAMBLE_MIN = 6'h20;
  localparam logic [4:0] HEAD_LAST    = 5'h0B;
  localparam logic [4:0] DATA_BITS    = 5'h10;
  localparam logic [4:0] DATA_LAST    = 5'h0F;
  localparam logic [4:0] TURN_LAST    = 5'h01;
  localparam int         OP_HI        = 11;
  localparam int         OP_LO        = 10;
  localparam int         PHY_HI       = 9;
  localparam int         PHY_LO       = 5;
  localparam int         REGNUM_HI    = 4;

  // Field positions
  localparam int CMD_OVR_BIT     = 15;
  localparam int ADDR_HI         = 10;
  localparam int ADDR_LO         = 6;
  localparam int CIPHER_TEST_BIT = 5;
  localparam int NRZI_BIT        = 3;
  localparam int TX_INVALID_BIT  = 2;
  localparam int CIPHER_OFF_BIT  = 0;
  localparam int SPEED_BIT       = 15;
  localparam int DUPLEX_BIT      = 14;
  localparam int PROG_HI         = 13;
  localparam int PROG_LO         = 11;
  localparam int PAGE_RSVD_BIT   = 14;

  localparam logic        PHYAD_TOP    = 1'b1;
  localparam logic [2:0]  STRAP_SETTLE = 3'h4;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam int          SYNC_WIDTH   = 6;

  typedef struct packed {
    logic cipherTest;
    logic nrzi;
    logic txInvalid;
    logic cipherOff;
  } tuning_t;

  localparam tuning_t TUNING_RESET = '{cipherTest: 1'b0, nrzi: 1'b1, txInvalid: 1'b0, cipherOff: 1'b0};

  typedef struct packed {
    logic       speed100;
    logic       fullDuplex;
    logic [2:0] progress;
  } link_status_t;

  typedef enum logic [5:0] {
    S_PRE   = 6'b000001,
    S_START = 6'b000010,
    S_HEAD  = 6'b000100,
    S_TURN  = 6'b001000,
    S_READ  = 6'b010000,
    S_WRITE = 6'b100000
  } mgmt_state_t;
endpackage

// ===== hdl/input_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module input_sync (
  input  wire logic                                clk,
  input  wire logic                                resetn,
  input  wire logic [phy_regs_pkg::SYNC_WIDTH-1:0] rawIn,
  output logic      [phy_regs_pkg::SYNC_WIDTH-1:0] syncOut
);
  logic [phy_regs_pkg::SYNC_WIDTH-1:0] ff1_q;
  logic [phy_regs_pkg::SYNC_WIDTH-1:0] ff2_q;
  logic [phy_regs_pkg::SYNC_WIDTH-1:0] ff3_q;
  logic [phy_regs_pkg::SYNC_WIDTH-1:0] out_q;
  logic [phy_regs_pkg::SYNC_WIDTH-1:0] out_d;

  for (genvar i = 0; i < phy_regs_pkg::SYNC_WIDTH; i++) begin : gBit
    always_comb begin
      out_d[i] = (ff2_q[i] == ff3_q[i]) ? ff2_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ff1_q <= '0;
      ff2_q <= '0;
      ff3_q <= '0;
      out_q <= '0;
    end else begin
      ff1_q <= rawIn;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule

// ===== tb/mgmt_station_model.sv
// Station management controller model driving management frames at the device pins
`timescale 1ns/10ps
module mgmt_station_model #(
  parameter int HALF = 8
) (
  input  wire logic clk,
  input  wire logic mdioOut,
  input  wire logic mdioOe,
  output logic      mdc,
  output logic      mdioPin
);
  logic drvEn;
  logic drvBit;

  // Pull-up holds the line high while nobody drives it
  assign mdioPin = mdioOe ? mdioOut : (drvEn ? drvBit : 1'h1);

  initial begin
    mdc = 1'h0;
    drvEn = 1'h0;
    drvBit = 1'h0;
  end

  // One management clock period; the line is sampled just before the rise
  task automatic pulse(output logic s);
    repeat (HALF) @(negedge clk);
    s = mdioPin;
    mdc = 1'h1;
    repeat (HALF) @(negedge clk);
    mdc = 1'h0;
  endtask

  // Whole frame, 16-bit word; rData holds the turnaround bit above the read word
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regNo,
                       input logic [15:0] wData, output logic [16:0] rData, output logic drove);
    logic [45:0] head;
    logic [17:0] tail;
    logic        s;
    head = {32'hFFFFFFFF, 2'h1, op, phy, regNo};
    tail = {2'h2, wData};
    rData = 17'h00000;
    drove = 1'h0;
    drvEn = 1'h1;
    for (int i = 45; i >= 0; i--) begin
      drvBit = head[i];
      pulse(s);
    end
    drvEn = (op == phy_regs_pkg::OP_WRITE);
    for (int i = 17; i >= 0; i--) begin
      drvBit = tail[i];
      pulse(s);
      drove = drove | mdioOe;
      if (i < 17) begin
        rData = {rData[15:0], s};
      end
    end
    drvEn = 1'h0;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ===== tb/phy_mgmt_regs_test.sv
// Testbench for the management register block with a station controller model
`timescale 1ns/10ps
module phy_mgmt_regs_test;
  localparam logic [3:0] STRAP = 4'hA;
  localparam logic [4:0] PHY   = {1'h1, STRAP};
  localparam logic [1:0] RD    = phy_regs_pkg::OP_READ;
  localparam logic [1:0] WR    = phy_regs_pkg::OP_WRITE;
  logic                       clk;
  logic                       resetn;
  logic [3:0]                 strap;
  logic                       mdc;
  logic                       mdioIn;
  logic                       mdioOut;
  logic                       mdioOe;
  logic [15:0]                pageCode;
  logic                       pageStrobe;
  phy_regs_pkg::link_status_t linkStatus;
  phy_regs_pkg::tuning_t      tuning;
  phy_regs_pkg::tuning_t      t;
  logic                       cmdOverride;
  logic [16:0]                rd;
  logic                       drove;
  int                         mismatches = 0;
  int                         checked = 0;
  int                         pulses = 0;
  int                         cycles = 0;

  phy_mgmt_regs phy_mgmt_regs_inst (.clk(clk), .resetn(resetn), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .strapAddr(strap), .pageCode(pageCode), .pageStrobe(pageStrobe),
    .linkStatus(linkStatus), .tuning(tuning), .cmdOverride(cmdOverride));
  mgmt_station_model mgmt_station_model_inst (.clk(clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc),
    .mdioPin(mdioIn));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cmdOverride === 1'h1) begin
      pulses <= pulses + 1;
    end
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic rw(input logic [1:0] op, input logic [4:0] regNo, input logic [15:0] wData);
    mgmt_station_model_inst.frame(op, PHY, regNo, wData, rd, drove);
  endtask

  function automatic logic [15:0] exp16(input phy_regs_pkg::tuning_t v);
    return {5'h00, PHY, v.cipherTest, 1'h0, v.nrzi, v.txInvalid, 1'h0, v.cipherOff};
  endfunction

  task automatic test_reset();
    check({13'h0, tuning}, {13'h0, phy_regs_pkg::TUNING_RESET});
    check({16'h0, cmdOverride}, 17'h0);
    rw(RD, 5'h10, 16'h0000);
    check(rd, {1'h0, exp16(phy_regs_pkg::TUNING_RESET)});
    rw(RD, 5'h08, 16'h0000);
    check(rd, 17'h00000);
    $display("test_reset done");
  endtask

  task automatic test_tuning();
    logic [15:0] vals [6] = '{16'h802D, 16'h0020, 16'h0008, 16'h0004, 16'h0001, 16'h0000};
    int          p0;
    foreach (vals[i]) begin
      p0 = pulses;
      t = phy_regs_pkg::tuning_t'({vals[i][5], vals[i][3], vals[i][2], vals[i][0]});
      rw(WR, 5'h10, vals[i]);
      check({13'h0, tuning}, {13'h0, t});
      check(17'(pulses - p0), {16'h0, vals[i][15]});
      rw(RD, 5'h10, 16'h0000);
      check(rd, {1'h0, exp16(t)});
    end
    $display("test_tuning done");
  endtask

  task automatic test_page();
    @(negedge clk);
    pageCode = 16'hFFFF;
    pageStrobe = 1'h1;
    @(negedge clk);
    pageStrobe = 1'h0;
    pageCode = 16'h0005;
    rw(RD, 5'h08, 16'h0000);
    check(rd, 17'h0BFFF);
    pageStrobe = 1'h1;
    @(negedge clk);
    pageStrobe = 1'h0;
    rw(RD, 5'h08, 16'h0000);
    check(rd, 17'h00005);
    $display("test_page done");
  endtask

  task automatic test_reserved();
    for (int r = 9; r <= 15; r++) begin
      rw(WR, 5'(r), 16'hFFFF);
      rw(RD, 5'(r), 16'h0000);
      check(rd, 17'h00000);
    end
    check({13'h0, tuning}, 17'h0);
    $display("test_reserved done");
  endtask

  task automatic test_status();
    logic [4:0] st [4] = '{5'h1D, 5'h0A, 5'h1F, 5'h00};
    foreach (st[i]) begin
      @(negedge clk);
      linkStatus = st[i];
      repeat (4) @(negedge clk);
      rw(RD, 5'h11, 16'h0000);
      check(rd, {1'h0, st[i], 11'h000});
    end
    $display("test_status done");
  endtask

  task automatic test_refused();
    mgmt_station_model_inst.frame(RD, {1'h1, ~STRAP}, 5'h10, 16'h0000, rd, drove);
    check({16'h0, drove}, 17'h0);
    mgmt_station_model_inst.frame(WR, {1'h1, ~STRAP}, 5'h10, 16'h0021, rd, drove);
    check({13'h0, tuning}, 17'h0);
    rw(2'h0, 5'h10, 16'h0021);
    check({16'h0, drove}, 17'h0);
    rw(2'h3, 5'h10, 16'h0021);
    check({16'h0, drove}, 17'h0);
    check({13'h0, tuning}, 17'h0);
    $display("test_refused done");
  endtask

  // Second reset with new straps: registers return to defaults and the address follows the straps
  task automatic test_restrap();
    @(negedge clk);
    resetn = 1'h0;
    strap = 4'h5;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    repeat (12) @(negedge clk);
    check({13'h0, tuning}, {13'h0, phy_regs_pkg::TUNING_RESET});
    check({16'h0, cmdOverride}, 17'h0);
    mgmt_station_model_inst.frame(RD, {1'h1, 4'h5}, 5'h10, 16'h0000, rd, drove);
    check(rd, 17'h00548);
    rw(RD, 5'h10, 16'h0000);
    check({16'h0, drove}, 17'h0);
    $display("test_restrap done");
  endtask

  initial begin
    resetn = 1'h0;
    strap = STRAP;
    pageCode = 16'h0000;
    pageStrobe = 1'h0;
    linkStatus = 5'h00;
    repeat (8) @(negedge clk);
    resetn = 1'h1;
    repeat (12) @(negedge clk);
    test_reset();
    test_tuning();
    test_page();
    test_reserved();
    test_status();
    test_refused();
    test_restrap();
    tally_and_finish();
  end
endmodule
